/* hw/window_watchdog_cfg.svh */
/*
 Register offsets, field positions, reset values and divider counts
 for the window watchdog. Assumes inclusion by bare name.
*/
`ifndef WINDOW_WATCHDOG_CFG_SVH
`define WINDOW_WATCHDOG_CFG_SVH
`define WWD_OFS_CTRL0 12'h000
`define WWD_OFS_CTRL1 12'h004
`define WWD_OFS_STAT 12'h008
`define WWD_EN_BIT 7
`define WWD_IE_BIT 10
`define WWD_PRS_HI 9
`define WWD_PRS_LO 7
`define WWD_CNT_RST 7'h7F
`define WWD_WIN_RST 7'h7F
`define WWD_EARLY_VAL 7'h40
`define WWD_EXPIRE_VAL 7'h3F
`define WWD_BASE_DIV 4096
`endif

/* hw/window_watchdog_pkg.sv */
/*
 Types shared by the window watchdog.
 Assumes the cfg header is compiled alongside.
*/
package window_watchdog_pkg;
   typedef logic [6:0] count_t;
   typedef logic [2:0] prescale_t;
   typedef enum logic [1:0] {
      ST_STOPPED = 2'b00,
      ST_RUNNING = 2'b01,
      ST_EXPIRED = 2'b11
   } wd_state_e;
endpackage

/* hw/window_watchdog.sv */
/*
 Window watchdog: 7-bit down counter, prescaler, APB slave.
 Assumes one clock, APB master in the same domain, and the system
 reset request fed back to arst_n by the surrounding reset logic.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`include "window_watchdog_cfg.svh"
module window_watchdog #(
   parameter int BASE_DIV = `WWD_BASE_DIV
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic deep_sleep,
   output logic early_irq,
   output logic expiry_signal,
   output logic [1:0] wd_state
);
   import window_watchdog_pkg::*;
   localparam int DIVW = 20;
   localparam logic [DIVW-1:0] BASE_M1 = DIVW'(BASE_DIV - 1);

   count_t count_field_r;
   count_t window_field_r;
   prescale_t prescale_select_r;
   logic early_irq_enable_r;
   logic early_warning_flag_r;
   logic [DIVW-1:0] div_r;
   wd_state_e state_r;
   logic divided_count_clock;

   function automatic logic [DIVW-1:0] div_limit(input prescale_t p);
      div_limit = (BASE_M1 << p) | ((DIVW'(1) << p) - DIVW'(1));
   endfunction

   // Writes take effect in the access phase; slave always answers at once
   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite;
   wire logic wr_c0 = wr && (paddr == `WWD_OFS_CTRL0);
   wire logic wr_c1 = wr && (paddr == `WWD_OFS_CTRL1);
   wire logic wr_st = wr && (paddr == `WWD_OFS_STAT);
   wire logic running = (state_r == ST_RUNNING);
   wire count_t wdata_cnt = pwdata[6:0];
   wire logic bad_low = wr_c0 && (wdata_cnt <= `WWD_EXPIRE_VAL);
   wire logic bad_win = wr_c0 && running &&
      (count_field_r > window_field_r);
   wire logic unmapped = !((paddr == `WWD_OFS_CTRL0) ||
      (paddr == `WWD_OFS_CTRL1) || (paddr == `WWD_OFS_STAT));

   // A count write restarts the prescaler, so it takes the tick's place;
   // >= keeps a prescale lowered mid-period from running past its limit
   assign divided_count_clock = running && !deep_sleep && !wr_c0 &&
      (div_r >= div_limit(prescale_select_r));

   // Prescaler freezes in deep sleep so the partial period is kept
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= '0;
      end else if (!running || wr_c0) begin
         div_r <= '0;
      end else if (!deep_sleep) begin
         div_r <= divided_count_clock ? '0 : div_r + DIVW'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_field_r <= `WWD_CNT_RST;
      end else if (wr_c0) begin
         count_field_r <= wdata_cnt;
      end else if (divided_count_clock && count_field_r != '0) begin
         count_field_r <= count_field_r - 7'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_STOPPED;
      end else begin
         case (state_r)
            ST_STOPPED: begin
               if (bad_low) begin
                  state_r <= ST_EXPIRED;
               end else if (wr_c0 && pwdata[`WWD_EN_BIT]) begin
                  state_r <= ST_RUNNING;
               end
            end
            ST_RUNNING: begin
               if (bad_low || bad_win ||
                   (divided_count_clock &&
                    count_field_r == `WWD_EARLY_VAL)) begin
                  state_r <= ST_EXPIRED;
               end
            end
            default: begin
               state_r <= ST_EXPIRED;
            end
         endcase
      end
   end

   // A count write of 0x3F or less is fatal even before the enable is set
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         expiry_signal <= 1'b0;
      end else if (bad_low || bad_win ||
                   (divided_count_clock &&
                    count_field_r == `WWD_EARLY_VAL)) begin
         expiry_signal <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         window_field_r <= `WWD_WIN_RST;
         prescale_select_r <= '0;
      end else if (wr_c1) begin
         window_field_r <= pwdata[6:0];
         prescale_select_r <= pwdata[`WWD_PRS_HI:`WWD_PRS_LO];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         early_irq_enable_r <= 1'b0;
      end else if (wr_c1 && pwdata[`WWD_IE_BIT]) begin
         early_irq_enable_r <= 1'b1;
      end
   end

   // Set wins over a same-cycle software clear
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         early_warning_flag_r <= 1'b0;
      end else if (divided_count_clock &&
                   count_field_r == `WWD_EARLY_VAL + 7'h01) begin
         early_warning_flag_r <= 1'b1;
      end else if (wr_st && !pwdata[0]) begin
         early_warning_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         early_irq <= 1'b0;
      end else begin
         early_irq <= early_warning_flag_r && early_irq_enable_r;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wd_state <= 2'b00;
      end else begin
         wd_state <= state_r;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && unmapped;
         if (psel && !penable && !pwrite) begin
            if (paddr == `WWD_OFS_CTRL0) begin
               prdata <= {24'h0, state_r != ST_STOPPED,
                  count_field_r};
            end else if (paddr == `WWD_OFS_CTRL1) begin
               prdata <= {21'h0, early_irq_enable_r, prescale_select_r,
                  window_field_r};
            end else if (paddr == `WWD_OFS_STAT) begin
               prdata <= {31'h0, early_warning_flag_r};
            end else begin
               prdata <= '0;
            end
         end
      end
   end

   property p_expire_at_3f;
      @(posedge sys_clk) disable iff (!arst_n)
      (running && divided_count_clock && count_field_r == 7'h40)
      |=> expiry_signal && count_field_r == 7'h3F;
   endproperty
   a_expire_at_3f: assert property (p_expire_at_3f)
      else $error("no expiry on reaching 3F");
   property p_en_sticky;
      @(posedge sys_clk) disable iff (!arst_n)
      (state_r != ST_STOPPED) |=> (state_r != ST_STOPPED);
   endproperty
   a_en_sticky: assert property (p_en_sticky)
      else $error("watchdog stopped after start");
   property p_ie_sticky;
      @(posedge sys_clk) disable iff (!arst_n)
      early_irq_enable_r |=> early_irq_enable_r;
   endproperty
   a_ie_sticky: assert property (p_ie_sticky)
      else $error("irq enable cleared");
   property p_flag_set;
      @(posedge sys_clk) disable iff (!arst_n)
      (divided_count_clock && count_field_r == 7'h41)
      |=> early_warning_flag_r && count_field_r == 7'h40;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("early flag not set at 40");
   property p_irq_level;
      @(posedge sys_clk) disable iff (!arst_n)
      ##1 early_irq == $past(early_warning_flag_r && early_irq_enable_r);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq level mismatch");
   property p_low_write;
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_c0 && pwdata[6:0] <= 7'h3F) |=> expiry_signal;
   endproperty
   a_low_write: assert property (p_low_write)
      else $error("low count write did not reset");
   property p_win_write;
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_c0 && running && count_field_r > window_field_r)
      |=> expiry_signal;
   endproperty
   a_win_write: assert property (p_win_write)
      else $error("early refresh did not reset");
   property p_load;
      @(posedge sys_clk) disable iff (!arst_n)
      wr_c0 |=> count_field_r == $past(pwdata[6:0]);
   endproperty
   a_load: assert property (p_load)
      else $error("count write not loaded");
   property p_sleep_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      (deep_sleep && !wr_c0) |=> $stable(count_field_r);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("counted in deep sleep");
   property p_step;
      @(posedge sys_clk) disable iff (!arst_n)
      (!wr_c0 && !divided_count_clock) |=> $stable(count_field_r);
   endproperty
   a_step: assert property (p_step)
      else $error("count moved without tick");
   property p_flag_clear;
      @(posedge sys_clk) disable iff (!arst_n)
      (wr_st && !pwdata[0] &&
       !(divided_count_clock && count_field_r == 7'h41))
      |=> !early_warning_flag_r;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("early flag not cleared by zero write");
   property p_flag_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      (early_warning_flag_r && !(wr_st && !pwdata[0]))
      |=> early_warning_flag_r;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("early flag dropped without a clear");
   property p_irq_needs_enable;
      @(posedge sys_clk) disable iff (!arst_n)
      !early_irq_enable_r |=> !early_irq;
   endproperty
   a_irq_needs_enable: assert property (p_irq_needs_enable)
      else $error("irq raised while disabled");
   property p_expiry_sticky;
      @(posedge sys_clk) disable iff (!arst_n)
      expiry_signal |=> expiry_signal;
   endproperty
   a_expiry_sticky: assert property (p_expiry_sticky)
      else $error("reset request dropped");
   property p_read_count;
      @(posedge sys_clk) disable iff (!arst_n)
      (psel && !penable && !pwrite && paddr == `WWD_OFS_CTRL0)
      |=> prdata[6:0] == $past(count_field_r);
   endproperty
   a_read_count: assert property (p_read_count)
      else $error("count read is not the live count");
   property p_ready_once;
      @(posedge sys_clk) disable iff (!arst_n)
      ##1 pready == $past(psel && !penable);
   endproperty
   a_ready_once: assert property (p_ready_once)
      else $error("pready not one cycle after setup");
   c_start: cover property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(running));
   c_flag: cover property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(early_warning_flag_r));
   c_expire: cover property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(expiry_signal));
   c_refresh: cover property (@(posedge sys_clk) disable iff (!arst_n)
      wr_c0 && running && count_field_r <= window_field_r &&
      count_field_r > 7'h3F);
   c_sleep: cover property (@(posedge sys_clk) disable iff (!arst_n)
      running && deep_sleep && div_r != '0);
endmodule // window_watchdog

/* verif/tb.sv */
/*
 Self-checking bench for the window watchdog: APB master tasks, an
 integer model of the counter, and reset, refresh and expiry scenarios.
 Assumes the design package, header and module are compiled first.
*/
`timescale 1ns/100ps
module tb;
   import window_watchdog_pkg::*;
   localparam int DIV = 4;
   logic sys_clk = 0;
   logic arst_n = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic deep_sleep = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, early_irq, expiry_signal, err;
   logic [1:0] wd_state;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 44016;
   int n, prescale_select, init, per, t, v;
   // Integer model of the registers, updated from the rules
   int m_cnt, m_win, m_prs, m_ie, m_en, m_flag, m_exp;

   window_watchdog #(.BASE_DIV(DIV)) window_watchdog_i (
      .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .deep_sleep(deep_sleep),
      .early_irq(early_irq), .expiry_signal(expiry_signal),
      .wd_state(wd_state));

   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Bounded so that a late test cannot hang the run
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic int model_read(logic [11:0] a);
      if (a == 12'h000)
         return ((m_en | m_exp) << 7) | m_cnt;
      else if (a == 12'h004)
         return (m_ie << 10) | (m_prs << 7) | m_win;
      else if (a == 12'h008)
         return m_flag;
      return 0;
   endfunction

   function automatic void model_write(logic [11:0] a, logic [31:0] d);
      if (a == 12'h000) begin
         if (d[6:0] <= 7'h3F || (m_en != 0 && m_exp == 0 && m_cnt > m_win))
            m_exp = 1;
         m_cnt = d[6:0];
         m_en = m_en | d[7];
      end else if (a == 12'h004) begin
         m_win = d[6:0];
         m_prs = d[9:7];
         m_ie = m_ie | d[10];
      end else if (a == 12'h008 && !d[0]) begin
         m_flag = 0;
      end
   endfunction

   function automatic int model_state();
      return m_exp ? 3 : m_en;
   endfunction

   // Request held until pready is sampled high at a rising edge
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      if (wr)
         model_write(a, d);
      psel <= 0;
      penable <= 0;
   endtask

   task automatic do_reset();
      m_cnt = 'h7F;
      m_win = 'h7F;
      m_prs = 0;
      m_ie = 0;
      m_en = 0;
      m_flag = 0;
      m_exp = 0;
      arst_n <= 0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1;
      @(posedge sys_clk);
   endtask

   task automatic wait_edges(logic sig_is_irq);
      n = 0;
      while ((sig_is_irq ? early_irq : expiry_signal) !== 1'b1 && n < 9000)
      begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   initial begin
      do_reset();
      apb(0, 12'h000, 0);
      check("ctrl0 reset", rd, model_read(12'h000));
      apb(0, 12'h004, 0);
      check("ctrl1 reset", rd, model_read(12'h004));
      apb(0, 12'h008, 0);
      check("status reset", rd, model_read(12'h008));
      apb(0, 12'h00C, 0);
      check("unmapped", {rd[30:0], err}, 32'h1);
      $display("test registers done");

      prescale_select = 2 + ($random(seed) & 1);
      init = 32'h60 + ($random(seed) & 15);
      per = DIV << prescale_select;
      apb(1, 12'h004, (1 << 10) | (prescale_select << 7) | 32'h50);
      apb(1, 12'h000, 32'h80 | init);
      t = (init - 32'h40) * per;
      wait_edges(1);
      check("irq delay", n >= t && n <= t + 4, 1);
      // Count now rests at 0x40 with the flag set, frozen by deep sleep
      m_cnt = 'h40;
      m_flag = 1;
      deep_sleep <= 1;
      apb(0, 12'h008, 0);
      check("flag", rd, model_read(12'h008));
      repeat (3 * per) @(posedge sys_clk);
      apb(0, 12'h000, 0);
      check("frozen count", rd, model_read(12'h000));
      // Rewrite of 0x40 is inside the window, so it is a legal refresh
      apb(1, 12'h000, 32'h40);
      apb(0, 12'h000, 0);
      check("enable sticks", rd, model_read(12'h000));
      apb(1, 12'h004, (prescale_select << 7) | 32'h50);
      apb(0, 12'h004, 0);
      check("irq enable", rd, model_read(12'h004));
      apb(1, 12'h008, 0);
      apb(0, 12'h008, 0);
      check("flag clear", rd, model_read(12'h008));
      check("irq level", early_irq, m_flag & m_ie);
      deep_sleep <= 0;
      apb(1, 12'h000, init);
      repeat (2) @(posedge sys_clk);
      check("no expiry", expiry_signal, m_exp);
      check("running", wd_state, model_state());
      // Waiting starts two edges after the refresh landed
      t = (init - 32'h3F) * per - 2;
      wait_edges(0);
      check("expiry delay", n >= t && n <= t + 4, 1);
      m_cnt = 'h3F;
      m_exp = 1;
      // The state output trails the expiry request by one register
      @(posedge sys_clk);
      check("expired", wd_state, model_state());
      $display("test countdown done");

      for (int i = 0; i < 2; i++) begin
         do_reset();
         v = i ? ($random(seed) & 63) : 63;
         apb(1, 12'h000, v);
         repeat (2) @(posedge sys_clk);
         check("low load", expiry_signal, m_exp);
         check("low load state", wd_state, model_state());
      end
      $display("test low load done");

      do_reset();
      apb(1, 12'h004, 32'h50);
      apb(1, 12'h000, 32'hFF);
      check("start", expiry_signal, m_exp);
      apb(1, 12'h000, 32'hFF);
      repeat (2) @(posedge sys_clk);
      check("early refresh", expiry_signal, m_exp);
      $display("test early refresh done");
      report_and_stop();
   end
endmodule // tb
